// file: pkg/rxf_pkg.sv
package rxf_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] ADDRH_OFS   = 8'h04;
    localparam logic [7:0] ADDRL_OFS   = 8'h08;
    localparam logic [7:0] HASHH_OFS   = 8'h0c;
    localparam logic [7:0] HASHL_OFS   = 8'h10;
    localparam logic [7:0] PATT_OFS    = 8'h14;
    localparam logic [7:0] WAKE_OFS    = 8'h18;
    // mac_control_reg fields
    localparam int CR_MCPASS  = 0;
    localparam int CR_PROMISC = 1;
    localparam int CR_INVERSE = 2;
    localparam int CR_HASHO   = 3;
    localparam int CR_HASHP   = 4;
    localparam int CR_BCDIS   = 5;
    localparam int CR_W       = 6;
    // wakeup_control_status fields
    localparam int WU_EN      = 0;
    localparam int WU_RCVD    = 1;
    localparam int WU_IRQEN   = 2;
    localparam int WU_PMEEN   = 3;
    // Filter command fields
    localparam int CMD_EN     = 0;
    localparam int CMD_MCAST  = 3;
    // Frame layout and filter structure
    localparam int ADDR_BYTES = 6;
    localparam int NFILT      = 4;
    localparam int MASK_W     = 31;
    localparam int PATT_WORDS = 8;
    localparam int PATT_CMD   = 4;
    localparam int PATT_OFF   = 5;
    localparam int PATT_CRCL  = 6;
    localparam int PATT_CRCH  = 7;
    // Reset values and CRC polynomials
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [31:0] CRC32_INI = 32'hffff_ffff;
    localparam logic [15:0] CRC16_INI = 16'hffff;
    localparam logic [31:0] CRC32_POL = 32'h04c1_1db7;
    localparam logic [15:0] CRC16_POL = 16'h8005;
endpackage : rxf_pkg

// file: logic/rxf_filter.sv
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module rxf_filter (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_we,
    input  wire logic        reg_re,
    output logic      [31:0] reg_rdata,
    input  wire logic        rx_valid,
    input  wire logic        rx_sof,
    input  wire logic        rx_eof,
    input  wire logic [7:0]  rx_data,
    input  wire logic        d1_state,
    output logic             decision_valid,
    output logic             frame_accept,
    output logic             irq,
    output logic             power_event_out
);
    // ************************************************
    // Functions
    // ************************************************
    // Bits enter least significant first, as on the wire
    function automatic logic [31:0] crc32_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[31] ^ d[i]) ? ((r << 1) ^ rxf_pkg::CRC32_POL) : (r << 1);
        end
        return r;
    endfunction : crc32_byte

    function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[15] ^ d[i]) ? ((r << 1) ^ rxf_pkg::CRC16_POL) : (r << 1);
        end
        return r;
    endfunction : crc16_byte

    // ************************************************
    // Registers
    // ************************************************
    logic [rxf_pkg::CR_W-1:0] cr_reg;
    logic [15:0]              addrh_reg;
    logic [31:0]              addrl_reg;
    logic [31:0]              hashh_reg;
    logic [31:0]              hashl_reg;
    logic [3:0]               wake_cs_reg;
    logic [31:0]              wakeup_pattern_filter_reg [rxf_pkg::PATT_WORDS];
    logic [2:0]               wptr_reg;
    logic [31:0]              rdata_next;

    wire sel_cr    = reg_addr == rxf_pkg::CTRL_OFS;
    wire sel_addrh = reg_addr == rxf_pkg::ADDRH_OFS;
    wire sel_addrl = reg_addr == rxf_pkg::ADDRL_OFS;
    wire sel_hashh = reg_addr == rxf_pkg::HASHH_OFS;
    wire sel_hashl = reg_addr == rxf_pkg::HASHL_OFS;
    wire sel_patt  = reg_addr == rxf_pkg::PATT_OFS;
    wire sel_wake  = reg_addr == rxf_pkg::WAKE_OFS;

    wire mcpass  = cr_reg[rxf_pkg::CR_MCPASS];
    wire promisc = cr_reg[rxf_pkg::CR_PROMISC];
    wire inverse = cr_reg[rxf_pkg::CR_INVERSE];
    wire hasho   = cr_reg[rxf_pkg::CR_HASHO];
    wire hashp   = cr_reg[rxf_pkg::CR_HASHP];
    wire bcdis   = cr_reg[rxf_pkg::CR_BCDIS];

    // Forced on in D1 regardless of the enable bit
    wire wake_active = wake_cs_reg[rxf_pkg::WU_EN] | d1_state;

    // Unmapped offsets read as zero
    assign rdata_next = sel_cr    ? {26'h0, cr_reg} :
                        sel_addrh ? {16'h0, addrh_reg} :
                        sel_addrl ? addrl_reg :
                        sel_hashh ? hashh_reg :
                        sel_hashl ? hashl_reg :
                        sel_patt  ? wakeup_pattern_filter_reg[wptr_reg] :
                        sel_wake  ? {28'h0, wake_cs_reg} : 32'h0000_0000;

    // ************************************************
    // Receive byte tracking
    // ************************************************
    logic [8:0]  cnt_reg;
    logic [47:0] da_reg;
    logic [31:0] hcrc_reg;
    logic        dec_vld_reg;
    logic        acc_reg;
    logic        eof_d_reg;
    logic        hit_reg;

    wire [8:0]  idx      = rx_sof ? 9'h000 : cnt_reg;
    wire        in_da    = idx < 9'(rxf_pkg::ADDR_BYTES);
    wire        last_da  = rx_valid && idx == 9'(rxf_pkg::ADDR_BYTES - 1);
    wire [31:0] hcrc_in  = rx_sof ? rxf_pkg::CRC32_INI : hcrc_reg;
    wire [31:0] hcrc_nx  = crc32_byte(hcrc_in, rx_data);
    wire [47:0] da_full  = {da_reg[39:0], rx_data};
    wire [47:0] station  = {addrh_reg, addrl_reg};
    wire        perf     = da_full == station;
    wire        mcast    = da_full[40];
    wire        all_ones = &da_full;
    wire [5:0]  hidx     = hcrc_nx[31:26];
    wire [31:0] hword    = hidx[5] ? hashh_reg : hashl_reg;
    wire        hash_hit = hword[hidx[4:0]];

    // Mode decode, in priority order
    wire mode_pass = promisc                          ? 1'b1 :
                     (mcpass && mcast)                ? 1'b1 :
                     inverse                          ? !perf :
                     (hasho && hashp)                 ? hash_hit :
                     (hashp && mcast)                 ? hash_hit :
                     perf;
    wire bc_block  = all_ones && bcdis && !promisc;
    // No frame passes while wake detection owns the receiver
    wire acc_next  = mode_pass && !bc_block && !wake_active;

    // A wake frame needs station or broadcast address, broadcast disable ignored
    wire wake_addr_next = perf || all_ones;
    logic wake_addr_reg;
    logic mc_reg;

    // ************************************************
    // Wake pattern filters
    // ************************************************
    logic [15:0] wcrc_reg [rxf_pkg::NFILT];
    logic [15:0] wcrc_nx  [rxf_pkg::NFILT];
    logic [rxf_pkg::NFILT-1:0] fpass;

    for (genvar f = 0; f < rxf_pkg::NFILT; f++) begin : g_filt
        wire [7:0]  cmd   = wakeup_pattern_filter_reg[rxf_pkg::PATT_CMD][8*f +: 8];
        wire [7:0]  off   = wakeup_pattern_filter_reg[rxf_pkg::PATT_OFF][8*f +: 8];
        wire [31:0] crcw  = wakeup_pattern_filter_reg[rxf_pkg::PATT_CRCL + f/2];
        wire [15:0] exp16 = crcw[16*(f%2) +: 16];
        wire [31:0] mask  = wakeup_pattern_filter_reg[f];
        wire [8:0]  rel   = idx - {1'b0, off};
        wire        inwin = idx >= {1'b0, off} && rel < 9'(rxf_pkg::MASK_W);
        wire        take  = rx_valid && inwin && mask[rel[4:0]];
        wire [15:0] base  = rx_sof ? rxf_pkg::CRC16_INI : wcrc_reg[f];
        assign wcrc_nx[f] = take ? crc16_byte(base, rx_data) : base;
        // Type bit set: multicast only; clear: unicast only
        assign fpass[f] = cmd[rxf_pkg::CMD_EN] && (cmd[rxf_pkg::CMD_MCAST] == mc_reg) &&
                          wcrc_reg[f] == exp16;
    end

    wire wake_hit = eof_d_reg && wake_active && wake_addr_reg && |fpass;
    // Hardware set beats a software clear in the same cycle
    wire wclr     = reg_we && sel_wake && reg_wdata[rxf_pkg::WU_RCVD];
    wire wrcvd_nx = hit_reg || (wake_cs_reg[rxf_pkg::WU_RCVD] && !wclr);

    // ************************************************
    // Sequential logic
    // ************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cr_reg    <= '0;
            addrh_reg <= '0;
            addrl_reg <= rxf_pkg::RST_WORD;
            hashh_reg <= rxf_pkg::RST_WORD;
            hashl_reg <= rxf_pkg::RST_WORD;
            wptr_reg  <= '0;
            reg_rdata <= rxf_pkg::RST_WORD;
        end else begin
            if (reg_we && sel_cr)
                cr_reg <= reg_wdata[rxf_pkg::CR_W-1:0];
            if (reg_we && sel_addrh)
                addrh_reg <= reg_wdata[15:0];
            if (reg_we && sel_addrl)
                addrl_reg <= reg_wdata;
            if (reg_we && sel_hashh)
                hashh_reg <= reg_wdata;
            if (reg_we && sel_hashl)
                hashl_reg <= reg_wdata;
            if (reg_we && sel_patt)
                wptr_reg <= wptr_reg + 3'h1;
            reg_rdata <= reg_re ? rdata_next : rxf_pkg::RST_WORD;
        end
    end

    // Mask bit 31 is kept at zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < rxf_pkg::PATT_WORDS; i++)
                wakeup_pattern_filter_reg[i] <= rxf_pkg::RST_WORD;
        end else if (reg_we && sel_patt) begin
            wakeup_pattern_filter_reg[wptr_reg] <= (wptr_reg < 3'(rxf_pkg::NFILT)) ? {1'b0, reg_wdata[30:0]} : reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_cs_reg <= '0;
        end else begin
            wake_cs_reg[rxf_pkg::WU_RCVD] <= wrcvd_nx;
            if (reg_we && sel_wake) begin
                wake_cs_reg[rxf_pkg::WU_EN]    <= reg_wdata[rxf_pkg::WU_EN];
                wake_cs_reg[rxf_pkg::WU_IRQEN] <= reg_wdata[rxf_pkg::WU_IRQEN];
                wake_cs_reg[rxf_pkg::WU_PMEEN] <= reg_wdata[rxf_pkg::WU_PMEEN];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg       <= '0;
            da_reg        <= '0;
            hcrc_reg      <= rxf_pkg::CRC32_INI;
            dec_vld_reg   <= 1'b0;
            acc_reg       <= 1'b0;
            eof_d_reg     <= 1'b0;
            hit_reg       <= 1'b0;
            wake_addr_reg <= 1'b0;
            mc_reg        <= 1'b0;
            for (int i = 0; i < rxf_pkg::NFILT; i++)
                wcrc_reg[i] <= rxf_pkg::CRC16_INI;
        end else begin
            dec_vld_reg <= last_da;
            eof_d_reg   <= rx_valid && rx_eof;
            hit_reg     <= wake_hit;
            if (rx_valid) begin
                cnt_reg <= (&idx) ? idx : idx + 9'h001;
                for (int i = 0; i < rxf_pkg::NFILT; i++)
                    wcrc_reg[i] <= wcrc_nx[i];
                if (in_da) begin
                    da_reg   <= da_full;
                    hcrc_reg <= hcrc_nx;
                end
            end
            // Decision held until the cycle after the frame's last byte, or until a new start of frame
            if (last_da) begin
                acc_reg       <= acc_next;
                wake_addr_reg <= wake_addr_next;
                mc_reg        <= mcast;
            end else if (eof_d_reg || (rx_valid && rx_sof)) begin
                acc_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq             <= 1'b0;
            power_event_out <= 1'b0;
        end else begin
            irq             <= wrcvd_nx && wake_cs_reg[rxf_pkg::WU_IRQEN];
            power_event_out <= wrcvd_nx && wake_cs_reg[rxf_pkg::WU_PMEEN];
        end
    end

    assign decision_valid = dec_vld_reg;
    assign frame_accept   = acc_reg;

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ************************************************
    // Decision checks
    // ************************************************
    decide_time_a: assert property (last_da |=> decision_valid)
        else $error("decision not one cycle after last address byte");

    hold_dec_a: assert property (!last_da && !eof_d_reg && !(rx_valid && rx_sof) |=> $stable(frame_accept))
        else $error("accept changed mid frame");

    promisc_a: assert property (last_da && promisc && !wake_active |=> frame_accept)
        else $error("promiscuous frame rejected");

    wake_block_a: assert property (last_da && wake_active |=> !frame_accept)
        else $error("frame accepted in wake mode");

    mcpass_a: assert property (last_da && mcpass && mcast && !bc_block && !wake_active |=> frame_accept)
        else $error("multicast dropped with pass all");

    inverse_a: assert property (last_da && inverse && !promisc && !(mcpass && mcast) && perf |=> !frame_accept)
        else $error("inverse filter passed own address");

    perfect_a: assert property (
        last_da && !promisc && !mcpass && !inverse && !hasho && !hashp && !bcdis && !wake_active
        |=> frame_accept == $past(perf))
        else $error("perfect match decision wrong");

    hash_perf_a: assert property (
        last_da && hashp && !hasho && !inverse && !promisc && !mcpass && !mcast && !bcdis && !wake_active
        |=> frame_accept == $past(perf))
        else $error("hash perfect physical decision wrong");

    hash_only_a: assert property (
        last_da && hashp && hasho && !inverse && !promisc && !mcpass && !bcdis && !wake_active
        |=> frame_accept == $past(hash_hit))
        else $error("hash only decision wrong");

    bc_drop_a: assert property (last_da && all_ones && bcdis && !promisc |=> !frame_accept)
        else $error("broadcast passed while disabled");

    accept_end_a: assert property (eof_d_reg && !last_da |=> !frame_accept)
        else $error("accept not cleared after frame end");

    dec_pulse_a: assert property (decision_valid |=> !decision_valid)
        else $error("decision strobe longer than one cycle");

    mcast_flag_a: assert property (last_da |=> mc_reg == $past(da_reg[32]))
        else $error("multicast flag not taken from first address bit");

    count_start_a: assert property (rx_valid && rx_sof |=> cnt_reg == 9'h001)
        else $error("byte count did not restart at frame start");

    // ************************************************
    // Wake checks
    // ************************************************
    wake_set_a: assert property (wake_hit |-> ##2 wake_cs_reg[rxf_pkg::WU_RCVD])
        else $error("wake status not set");

    power_evt_a: assert property (wake_hit && wake_cs_reg[rxf_pkg::WU_PMEEN] && !(reg_we && sel_wake) |-> ##2 power_event_out)
        else $error("power event missing");

    set_wins_a: assert property (hit_reg |=> wake_cs_reg[rxf_pkg::WU_RCVD])
        else $error("wake status lost to a clear");

    rcvd_clear_a: assert property (wclr && !hit_reg |=> !wake_cs_reg[rxf_pkg::WU_RCVD])
        else $error("wake status not cleared");

    rcvd_hold_a: assert property (wake_cs_reg[rxf_pkg::WU_RCVD] && !wclr |=> wake_cs_reg[rxf_pkg::WU_RCVD])
        else $error("wake status dropped without clear");

    irq_cause_a: assert property (irq |-> wake_cs_reg[rxf_pkg::WU_RCVD])
        else $error("interrupt without wake status");

    power_cause_a: assert property (power_event_out |-> wake_cs_reg[rxf_pkg::WU_RCVD])
        else $error("power event without wake status");

    wake_idle_a: assert property (eof_d_reg && !wake_active |=> !hit_reg)
        else $error("wake frame seen outside detection mode");

    // ************************************************
    // Register checks
    // ************************************************
    wptr_a: assert property (reg_we && sel_patt |=> wptr_reg == $past(wptr_reg) + 3'h1)
        else $error("filter pointer did not advance");

    patt_wrap_a: assert property (reg_we && sel_patt && wptr_reg == 3'h7 |=> wptr_reg == 3'h0)
        else $error("filter pointer did not wrap");

    mask_top_a: assert property (!(wakeup_pattern_filter_reg[0][31] | wakeup_pattern_filter_reg[1][31] | wakeup_pattern_filter_reg[2][31] | wakeup_pattern_filter_reg[3][31]))
        else $error("mask bit 31 set");

    ctrl_write_a: assert property (reg_we && sel_cr |=> cr_reg == $past(reg_wdata[rxf_pkg::CR_W-1:0]))
        else $error("control write lost");

    station_write_a: assert property (reg_we && sel_addrl |=> addrl_reg == $past(reg_wdata))
        else $error("station address write lost");

    // Read data must not linger past its one cycle
    rdata_idle_a: assert property (!reg_re |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");
endmodule : rxf_filter
`default_nettype wire

// file: tb/rxf_rx_src.sv
`timescale 1ns/1ps
`default_nettype none
module rxf_rx_src (
    input  wire logic       clk,
    output logic            rx_valid,
    output logic            rx_sof,
    output logic            rx_eof,
    output logic [7:0]      rx_data
);
    // ****************************************
    // Receive path byte source
    // ****************************************
    localparam int FRAME_LEN = 24;

    initial begin
        rx_valid = 1'b0;
        rx_sof   = 1'b0;
        rx_eof   = 1'b0;
        rx_data  = 8'h00;
    end

    // Six address bytes first, most significant byte leading; payload byte i is i xor pat
    task automatic send(input logic [47:0] da, input logic [7:0] pat);
        for (int i = 0; i < FRAME_LEN; i++) begin
            if (i == 3) begin
                // Idle gap mid-address: stale data is inverted so it cannot pass for a byte
                @(posedge clk);
                rx_valid <= 1'b0;
                rx_data  <= ~rx_data;
            end
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_sof   <= (i == 0);
            rx_eof   <= (i == FRAME_LEN - 1);
            rx_data  <= (i < 6) ? da[47 - 8 * i -: 8] : (8'(i) ^ pat);
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_eof   <= 1'b0;
        rx_data  <= ~rx_data;
    endtask : send
endmodule : rxf_rx_src
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ****************************************
    // Signals and instances
    // ****************************************
    localparam logic [47:0] ST  = 48'h0a1b_2c3d_4e5f;
    localparam logic [47:0] OTH = 48'h0a1b_2c3d_4e5e;
    localparam logic [47:0] MC1 = 48'h0100_5e00_0001;
    localparam logic [47:0] MC2 = 48'h3300_0000_0002;
    localparam logic [47:0] BC  = 48'hffff_ffff_ffff;
    logic        clk;
    logic        rst_n;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_we;
    logic        reg_re;
    logic [31:0] reg_rdata;
    logic        rx_valid;
    logic        rx_sof;
    logic        rx_eof;
    logic [7:0]  rx_data;
    logic        d1_state;
    logic        decision_valid;
    logic        frame_accept;
    logic        irq;
    logic        power_event_out;
    logic        dec_acc;
    logic        any_acc;
    logic [63:0] tbl;
    logic [15:0] pcrc;
    int          dec_cnt;
    int          num_errors;
    int          tests_run;
    int          cycles;

    rxf_filter dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof),
        .rx_data(rx_data), .d1_state(d1_state), .decision_valid(decision_valid), .frame_accept(frame_accept),
        .irq(irq), .power_event_out(power_event_out));
    rxf_rx_src src_u (.clk(clk), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_data(rx_data));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Outputs are registered, so reading them at the edge sees the settled value of the cycle before
    always @(posedge clk) begin
        cycles++;
        if (decision_valid === 1'b1)
            dec_acc = frame_accept;
        if (decision_valid === 1'b1)
            dec_cnt++;
        if (frame_accept === 1'b1)
            any_acc = 1'b1;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_re   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re   <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    function automatic logic [5:0] hidx(input logic [47:0] da);
        logic [31:0] c;
        logic        fb;
        c = rxf_pkg::CRC32_INI;
        for (int k = 0; k < 48; k++) begin
            fb = c[31] ^ da[40 - 8 * (k / 8) + (k % 8)];
            c = {c[30:0], 1'b0} ^ (fb ? rxf_pkg::CRC32_POL : 32'h0);
        end
        return c[31:26];
    endfunction : hidx

    function automatic logic [15:0] crc16(input logic [7:0] b);
        logic [15:0] c;
        logic        fb;
        c = rxf_pkg::CRC16_INI;
        for (int k = 0; k < 8; k++) begin
            fb = c[15] ^ b[k];
            c = {c[14:0], 1'b0} ^ (fb ? rxf_pkg::CRC16_POL : 16'h0);
        end
        return c;
    endfunction : crc16

    task automatic frame(input logic [47:0] da, input logic [7:0] pat, input logic exp);
        #1;
        dec_acc = 1'b0;
        any_acc = 1'b0;
        dec_cnt = 0;
        src_u.send(da, pat);
        @(posedge clk);
        #1;
        chk(32'(dec_acc), 32'(exp));
        chk(32'(any_acc), 32'(exp));
        chk(32'(frame_accept), 32'h0);
        chk(32'(dec_cnt), 32'h1);
    endtask : frame

    task automatic mode(input logic [31:0] cr, input logic [47:0] da, input logic exp);
        wr(8'h00, cr);
        frame(da, 8'h00, exp);
    endtask : mode

    task automatic wake(input logic [47:0] da, input logic [7:0] pat, input logic [31:0] cr, input logic [31:0] wu,
                        input logic d1, input logic exp);
        wr(8'h00, cr);
        wr(8'h18, wu);
        d1_state <= d1;
        frame(da, pat, 1'b0);
        repeat (6) @(posedge clk);
        #1;
        chk(32'(power_event_out), 32'(exp & wu[3]));
        chk(32'(irq), 32'(exp & wu[2]));
        rd(8'h18, wu | 32'({exp, 1'b0}));
        d1_state <= 1'b0;
        wr(8'h18, 32'h0000_0002);
        rd(8'h18, 32'h0);
    endtask : wake

    task automatic print_verdict();
        if (num_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_we = 1'b0;
        reg_re = 1'b0;
        d1_state = 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h00, 32'h0);
        rd(8'h18, 32'h0);
        wr(8'h1c, 32'hffff_ffff);
        rd(8'h1c, 32'h0);
        wr(8'h04, 32'hffff_0a1b);
        wr(8'h08, 32'h2c3d_4e5f);
        rd(8'h04, 32'h0000_0a1b);
        tbl = (64'h1 << hidx(MC1)) | (64'h1 << hidx(OTH));
        wr(8'h0c, tbl[63:32]);
        wr(8'h10, tbl[31:0]);
        mode(32'h00, ST, 1'b1);
        mode(32'h00, OTH, 1'b0);
        mode(32'h00, MC1, 1'b0);
        mode(32'h04, ST, 1'b0);
        mode(32'h04, OTH, 1'b1);
        mode(32'h22, BC, 1'b1);
        mode(32'h02, OTH, 1'b1);
        mode(32'h20, BC, 1'b0);
        mode(32'h01, MC2, 1'b1);
        mode(32'h01, OTH, 1'b0);
        mode(32'h19, OTH, 1'b1);
        mode(32'h10, MC1, 1'b1);
        mode(32'h10, MC2, tbl[hidx(MC2)]);
        mode(32'h10, OTH, 1'b0);
        mode(32'h10, ST, 1'b1);
        mode(32'h18, OTH, 1'b1);
        mode(32'h18, ST, tbl[hidx(ST)]);
        // Filter 0 unicast, filter 1 multicast, both on byte 14 of the frame
        pcrc = crc16(8'h0e);
        wr(8'h14, 32'h0000_0001);
        wr(8'h14, 32'h0000_0001);
        wr(8'h14, 32'h0);
        wr(8'h14, 32'h0);
        wr(8'h14, 32'h0000_0901);
        wr(8'h14, 32'h0000_0e0e);
        wr(8'h14, {pcrc, pcrc});
        wr(8'h14, 32'h0);
        rd(8'h14, 32'h0000_0001);
        wake(ST, 8'h00, 32'h00, 32'h0000_000d, 1'b0, 1'b1);
        wake(ST, 8'h80, 32'h00, 32'h0000_000d, 1'b0, 1'b0);
        wake(MC1, 8'h00, 32'h00, 32'h0000_000d, 1'b0, 1'b0);
        wake(BC, 8'h00, 32'h20, 32'h0000_0005, 1'b0, 1'b1);
        wake(ST, 8'h00, 32'h00, 32'h0, 1'b1, 1'b1);
        mode(32'h00, ST, 1'b1);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
